// *** logic/pid_pkg.sv ***
// Shared constants for the process regulator
`default_nettype none
package pid_pkg;
  // ===========================================================
  // Fixed-point scaling: percentages in tenths of a percent
  localparam logic [10:0] PCT_FULL = 11'h3E8;
  localparam logic [9:0] PCT_DIV = 10'h3E8;
  localparam longint GAIN_SCALE = 64'd10000000;
  // ===========================================================
  // Feedback source codes
  localparam logic [2:0] FB_AI1 = 3'h0;
  localparam logic [2:0] FB_AI2 = 3'h1;
  localparam logic [2:0] FB_SUM = 3'h2;
  localparam logic [2:0] FB_DIFF = 3'h3;
  localparam logic [2:0] FB_COMM = 3'h4;
  // ===========================================================
  // Setpoint source codes
  localparam logic [2:0] SP_DIGITAL = 3'h0;
  localparam logic [2:0] SP_AI1 = 3'h1;
  localparam logic [2:0] SP_AI2 = 3'h2;
  localparam logic [2:0] SP_COMM = 3'h3;
  localparam logic [2:0] SP_MULTI = 3'h4;
  // ===========================================================
  // Polarity codes
  localparam logic POL_POSITIVE = 1'h0;
  localparam logic POL_NEGATIVE = 1'h1;
  // ===========================================================
  // Timing: base tick of 10 ms, tenth-second steps of 10 ticks
  localparam int CLK_PERIOD_NS = 8;
  localparam int TICK_TIME_NS = 10000000;
  localparam int TICK_CYCLES = (TICK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] TICKS_PER_TENTH = 4'hA;
  localparam logic [13:0] SAMPLE_AUTO = 14'h000A;
endpackage : pid_pkg
`default_nettype wire

// *** logic/pid_tick_if.sv ***
// Timebase signals between the regulator core and its timer
`timescale 1ns/1ps
`default_nettype none
interface pid_tick_if;
  logic [13:0] period;
  logic tick;
  logic tenth;
  logic sample;
  modport timer (input period, output tick, output tenth, output sample);
  modport core (output period, input tick, input tenth, input sample);
endinterface : pid_tick_if
`default_nettype wire

// *** logic/pid_sample_timer.sv ***
// Timebase: 10 ms tick, tenth-second pulse and sampling strobe
`timescale 1ns/1ps
`default_nettype none
module pid_sample_timer #(
  parameter int TICK_CYCLES = pid_pkg::TICK_CYCLES
) (
  input wire logic mclk,
  input wire logic nrst,
  pid_tick_if.timer tb
);
  logic [31:0] pre_r;
  logic [3:0] tenth_cnt_r;
  logic [13:0] samp_cnt_r;
  logic tick_r;
  logic tenth_r;
  logic sample_r;
  wire pre_wrap = (pre_r == 32'(TICK_CYCLES - 1));
  wire tenth_wrap = (tenth_cnt_r == pid_pkg::TICKS_PER_TENTH - 4'h1);
  wire samp_wrap = (samp_cnt_r >= tb.period - 14'h0001);

  // ===========================================================
  // Prescaler and tick counters
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      pre_r <= 32'h0;
      tenth_cnt_r <= 4'h0;
      samp_cnt_r <= 14'h0;
      tick_r <= 1'b0;
      tenth_r <= 1'b0;
      sample_r <= 1'b0;
    end else begin
      pre_r <= pre_wrap ? 32'h0 : pre_r + 32'h1;
      tick_r <= pre_wrap;
      tenth_r <= pre_wrap && tenth_wrap;
      sample_r <= pre_wrap && samp_wrap;
      if (pre_wrap) begin
        tenth_cnt_r <= tenth_wrap ? 4'h0 : tenth_cnt_r + 4'h1;
        samp_cnt_r <= samp_wrap ? 14'h0 : samp_cnt_r + 14'h1;
      end
    end
  end

  assign tb.tick = tick_r;
  assign tb.tenth = tenth_r;
  assign tb.sample = sample_r;
endmodule : pid_sample_timer
`default_nettype wire

// *** logic/process_pid_regulator.sv ***
// Process closed-loop regulator feeding the drive frequency command
// Summary of operation
// - Difference feedback is first minus second input, zero when first <= second.
// - Feedback select: 0 first, 1 second, 2 sum, 3 clamped difference, 4 link.
// - Polarity 0 keeps regulator sense, 1 inverts it.
// - Digital setpoint, 0 to 100 percent, used under digital setpoint selection and for unused codes 5 to 7.
// - Setpoint select 3 takes link value, 4 takes multi-speed stage value.
// - Gain 100 with full-scale deviation gives maximum frequency adjustment.
// - Constant full-scale deviation integrates to maximum frequency in one integral time.
// - Derivative acts on deviation change; full change per derivative time gives maximum.
// - Update once per sampling period, 0.01 to 100 s, zero means automatic.
// - Output held while absolute deviation over setpoint lies within the limit.
// - Feedback at or below loss level for loss time raises loss fault.
// - Sleep after delay when near lower limit and feedback beyond sleep threshold.
// - Wake after delay when feedback crosses wakeup threshold back toward demand.
`timescale 1ns/1ps
`default_nettype none
module process_pid_regulator #(
  parameter int TICK_CYCLES = pid_pkg::TICK_CYCLES
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic [10:0] analog_input_one,
  input wire logic [10:0] analog_input_two,
  input wire logic [10:0] comm_feedback,
  input wire logic [10:0] comm_setpoint,
  input wire logic [10:0] multi_speed_setpoint,
  input wire logic [10:0] digital_setpoint,
  input wire logic [2:0] setpoint_source_select,
  input wire logic [2:0] feedback_source_select,
  input wire logic output_polarity,
  input wire logic [15:0] proportional_gain,
  input wire logic [15:0] integral_time,
  input wire logic [15:0] derivative_time,
  input wire logic [13:0] sampling_period,
  input wire logic [10:0] deviation_limit,
  input wire logic [10:0] loss_detect_level,
  input wire logic [15:0] loss_detect_time,
  input wire logic [10:0] sleep_threshold,
  input wire logic [10:0] wakeup_threshold,
  input wire logic [15:0] sleep_wake_delay,
  input wire logic [15:0] maximum_frequency,
  input wire logic signed [16:0] frequency_base,
  input wire logic near_lower_limit,
  input wire logic loss_fault_clear,
  output logic signed [16:0] frequency_command,
  output logic signed [16:0] regulator_output,
  output logic [10:0] setpoint_value,
  output logic [10:0] feedback_value,
  output logic loss_fault,
  output logic sleeping,
  output logic sample_done
);
  typedef enum logic [0:0] {ST_RUN, ST_SLEEP} sleep_state_e;

  pid_tick_if tb ();

  // ===========================================================
  // Timebase
  pid_sample_timer #(.TICK_CYCLES(TICK_CYCLES)) u_timer (
    .mclk(mclk),
    .nrst(nrst),
    .tb(tb.timer)
  );
  assign tb.period = (sampling_period == 14'h0) ? pid_pkg::SAMPLE_AUTO : sampling_period;

  // ===========================================================
  // Source selection
  // Sum can reach twice full scale; clamped so the summed feedback stays in 0..100.0%
  wire [11:0] ai_sum = {1'b0, analog_input_one} + {1'b0, analog_input_two};
  wire [10:0] ai_sum_sat = (ai_sum > {1'b0, pid_pkg::PCT_FULL}) ? pid_pkg::PCT_FULL : ai_sum[10:0];
  wire [10:0] ai_diff = (analog_input_one <= analog_input_two) ? 11'h0 : analog_input_one - analog_input_two;
  logic [10:0] fb_sel;
  logic [10:0] sp_sel;
  // Feedback and setpoint multiplexers; unused codes fall back to safe defaults
  always_comb begin
    unique case (feedback_source_select)
      pid_pkg::FB_AI1: fb_sel = analog_input_one;
      pid_pkg::FB_AI2: fb_sel = analog_input_two;
      pid_pkg::FB_SUM: fb_sel = ai_sum_sat;
      pid_pkg::FB_DIFF: fb_sel = ai_diff;
      pid_pkg::FB_COMM: fb_sel = comm_feedback;
      default: fb_sel = analog_input_one;
    endcase
  end
  always_comb begin
    unique case (setpoint_source_select)
      pid_pkg::SP_DIGITAL: sp_sel = digital_setpoint;
      pid_pkg::SP_AI1: sp_sel = analog_input_one;
      pid_pkg::SP_AI2: sp_sel = analog_input_two;
      pid_pkg::SP_COMM: sp_sel = comm_setpoint;
      pid_pkg::SP_MULTI: sp_sel = multi_speed_setpoint;
      default: sp_sel = digital_setpoint;
    endcase
  end

  // ===========================================================
  // Deviation, polarity and dead band
  wire signed [12:0] fb_s = $signed({2'b00, fb_sel});
  wire signed [12:0] sp_s = $signed({2'b00, sp_sel});
  wire signed [12:0] err = (output_polarity == pid_pkg::POL_NEGATIVE) ? fb_s - sp_s : sp_s - fb_s;
  wire [11:0] abs_err = err[12] ? 12'(-err) : err[11:0];
  wire [21:0] band_lhs = 22'(abs_err) * 22'(pid_pkg::PCT_DIV);
  wire [21:0] band_rhs = 22'(deviation_limit) * 22'(sp_sel);
  wire in_band = (band_lhs <= band_rhs);

  // ===========================================================
  // Term arithmetic; wide signed math avoids overflow of the products
  logic signed [16:0] err_prev_r;
  logic signed [17:0] integ_r;
  wire signed [63:0] fmax_w = $signed({48'h0, maximum_frequency});
  wire signed [63:0] err_w = 64'(err);
  wire signed [63:0] dlt_w = 64'(err) - 64'(err_prev_r);
  wire signed [63:0] ts_w = $signed({50'h0, tb.period});
  wire signed [63:0] ti_w = $signed({48'h0, integral_time});
  wire signed [63:0] p_w = ($signed({48'h0, proportional_gain}) * err_w * fmax_w) / pid_pkg::GAIN_SCALE;
  // Zero integral time switches the integrator off rather than dividing by zero
  wire signed [63:0] i_inc = (integral_time == 16'h0) ? 64'sd0
    : (err_w * fmax_w * ts_w) / (ti_w * 64'sd1000);
  wire signed [63:0] d_w = ($signed({48'h0, derivative_time}) * dlt_w * fmax_w) / (ts_w * 64'sd1000);

  // Saturation to plus/minus maximum frequency
  function automatic logic signed [63:0] clamp_fmax(input logic signed [63:0] v, input logic signed [63:0] lim);
    clamp_fmax = (v > lim) ? lim : ((v < -lim) ? -lim : v);
  endfunction : clamp_fmax

  wire signed [63:0] integ_nxt_w = clamp_fmax(64'(integ_r) + i_inc, fmax_w);
  wire signed [63:0] sum_w = clamp_fmax(p_w + integ_nxt_w + d_w, fmax_w);
  wire signed [63:0] cmd_w = clamp_fmax(64'(frequency_base) + 64'(regulator_output), fmax_w);
  wire update = tb.sample && !sleeping && !in_band;

  // ===========================================================
  // Regulator state: updated once per sampling strobe, cleared every cycle while asleep
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      integ_r <= 18'sh0;
      err_prev_r <= 17'sh0;
      regulator_output <= 17'sh0;
    end else if (sleeping) begin
      integ_r <= 18'sh0;
      err_prev_r <= 17'(err);
      regulator_output <= 17'sh0;
    end else if (tb.sample) begin
      err_prev_r <= 17'(err);
      if (update) begin
        integ_r <= 18'(integ_nxt_w);
        regulator_output <= 17'(sum_w);
      end
    end
  end

  // ===========================================================
  // Command path and monitors; zero speed while asleep
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      frequency_command <= 17'sh0;
      setpoint_value <= 11'h0;
      feedback_value <= 11'h0;
      sample_done <= 1'b0;
    end else begin
      frequency_command <= sleeping ? 17'sh0 : 17'(cmd_w);
      setpoint_value <= sp_sel;
      feedback_value <= fb_sel;
      sample_done <= update;
    end
  end

  // ===========================================================
  // Feedback loss watch, counted in tenths of a second
  // Uses the live selection, one cycle ahead of the feedback monitor port
  logic [15:0] loss_cnt_r;
  wire fb_low = (fb_sel <= loss_detect_level);
  wire loss_hit = fb_low && (loss_cnt_r >= loss_detect_time);
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      loss_cnt_r <= 16'h0;
      loss_fault <= 1'b0;
    end else begin
      if (!fb_low) begin
        loss_cnt_r <= 16'h0;
      end else if (tb.tenth && !loss_hit) begin
        loss_cnt_r <= loss_cnt_r + 16'h1;
      end
      // Set wins over a clear in the same cycle
      loss_fault <= loss_hit || (loss_fault && !loss_fault_clear);
    end
  end

  // ===========================================================
  // Sleep and wakeup sequencing
  sleep_state_e st_r;
  sleep_state_e st_nxt;
  logic [15:0] dly_cnt_r;
  wire neg_pol = (output_polarity == pid_pkg::POL_NEGATIVE);
  wire sleep_cond = near_lower_limit && (neg_pol ? fb_sel < sleep_threshold : fb_sel > sleep_threshold);
  // Negative polarity wakes above the threshold, the only sense that fits the ordering
  wire wake_cond = neg_pol ? (fb_sel > wakeup_threshold) : (fb_sel < wakeup_threshold);
  wire cond = (st_r == ST_RUN) ? sleep_cond : wake_cond;
  wire dly_done = cond && (dly_cnt_r >= sleep_wake_delay);
  // Next state; one delay counter serves both directions
  always_comb begin
    st_nxt = st_r;
    unique case (st_r)
      ST_RUN: if (dly_done) st_nxt = ST_SLEEP;
      ST_SLEEP: if (dly_done) st_nxt = ST_RUN;
    endcase
  end
  // Counter restarts whenever the condition drops, so a brief excursion never toggles
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      st_r <= ST_RUN;
      dly_cnt_r <= 16'h0;
      sleeping <= 1'b0;
    end else begin
      st_r <= st_nxt;
      sleeping <= (st_nxt == ST_SLEEP);
      if (!cond || dly_done) begin
        dly_cnt_r <= 16'h0;
      end else if (tb.tenth) begin
        dly_cnt_r <= dly_cnt_r + 16'h1;
      end
    end
  end
endmodule : process_pid_regulator
`default_nettype wire

// *** verif/pid_checker.sv ***
// Port assertions for the process regulator
`timescale 1ns/1ps
`default_nettype none
module pid_checker #(
  parameter int TICK_CYCLES = 4
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic [10:0] analog_input_one,
  input wire logic [10:0] analog_input_two,
  input wire logic [10:0] comm_feedback,
  input wire logic [2:0] feedback_source_select,
  input wire logic [10:0] loss_detect_level,
  input wire logic [15:0] maximum_frequency,
  input wire logic signed [16:0] frequency_base,
  input wire logic loss_fault_clear,
  input wire logic signed [16:0] frequency_command,
  input wire logic signed [16:0] regulator_output,
  input wire logic [10:0] feedback_value,
  input wire logic loss_fault,
  input wire logic sleeping,
  input wire logic sample_done
);
  // ==========================================================
  // Reference feedback and saturated command
  logic [11:0] sum_w;
  logic [10:0] dif_w;
  logic [10:0] fb_w;
  logic signed [18:0] fm_w;
  logic signed [18:0] raw_w;
  logic signed [16:0] cmd_w;
  logic low_w;
  assign sum_w = analog_input_one + analog_input_two;
  assign dif_w = analog_input_one > analog_input_two ? analog_input_one - analog_input_two : 11'h000;
  assign fb_w = feedback_source_select == 3'h1 ? analog_input_two :
    feedback_source_select == 3'h2 ? (sum_w > 12'h3E8 ? 11'h3E8 : sum_w[10:0]) :
    feedback_source_select == 3'h3 ? dif_w : feedback_source_select == 3'h4 ? comm_feedback : analog_input_one;
  assign fm_w = $signed({3'h0, maximum_frequency});
  assign raw_w = frequency_base + regulator_output;
  assign cmd_w = raw_w > fm_w ? fm_w[16:0] : raw_w < -fm_w ? -fm_w[16:0] : raw_w[16:0];
  assign low_w = feedback_value <= loss_detect_level;
  // ==========================================================
  // Properties; the gap check assumes TICK_CYCLES of 4 or more
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  property p_fb; $past(nrst) |-> feedback_value == $past(fb_w); endproperty
  a_fb: assert property (p_fb) else $error("feedback select mismatch");
  property p_clamp; regulator_output <= fm_w && regulator_output >= -fm_w; endproperty
  a_clamp: assert property (p_clamp) else $error("regulator output beyond limit");
  property p_hold; !sample_done && !sleeping |-> $stable(regulator_output); endproperty
  a_hold: assert property (p_hold) else $error("output moved between samples");
  property p_gap; sample_done |=> !sample_done [*3]; endproperty
  a_gap: assert property (p_gap) else $error("samples too close");
  property p_cmd; !sleeping |=> sleeping || frequency_command == $past(cmd_w); endproperty
  a_cmd: assert property (p_cmd) else $error("command not saturated sum");
  property p_sticky; loss_fault && !loss_fault_clear |=> loss_fault; endproperty
  a_sticky: assert property (p_sticky) else $error("loss fault dropped");
  property p_why; $rose(loss_fault) |-> low_w; endproperty
  a_why: assert property (p_why) else $error("loss fault without low feedback");
  property p_sleep; sleeping && $past(sleeping) |-> frequency_command == 0 && regulator_output == 0; endproperty
  a_sleep: assert property (p_sleep) else $error("output while asleep");
endmodule : pid_checker
bind process_pid_regulator pid_checker #(.TICK_CYCLES(TICK_CYCLES)) chk (.mclk, .nrst, .analog_input_one,
  .analog_input_two, .comm_feedback, .feedback_source_select, .loss_detect_level, .maximum_frequency,
  .frequency_base, .loss_fault_clear, .frequency_command, .regulator_output, .feedback_value, .loss_fault,
  .sleeping, .sample_done);
`default_nettype wire

// *** verif/sensor_model.sv ***
// Process sensors and link feedback seen by the regulator
`timescale 1ns/1ps
`default_nettype none
module sensor_model (
  input wire logic [10:0] lvl_one,
  input wire logic [10:0] lvl_two,
  input wire logic [10:0] lvl_link,
  output logic [10:0] analog_input_one,
  output logic [10:0] analog_input_two,
  output logic [10:0] comm_feedback
);
  // Transmitters saturate at full scale, never beyond
  assign analog_input_one = lvl_one > 11'h3E8 ? 11'h3E8 : lvl_one;
  assign analog_input_two = lvl_two > 11'h3E8 ? 11'h3E8 : lvl_two;
  assign comm_feedback = lvl_link > 11'h3E8 ? 11'h3E8 : lvl_link;
endmodule : sensor_model
`default_nettype wire

// *** verif/tb.sv ***
// Self-checking bench for the process regulator
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic mclk, nrst = 1'b0, pol = 1'b0, nll = 1'b0, lclr = 1'b0, lf, slp, sd;
  logic [10:0] l1 = 11'h000, l2 = 11'h000, lc = 11'h000, csp = 11'h3E8, msp = 11'h000, dsp = 11'h000;
  logic [10:0] dlim = 11'h000, llvl = 11'h000, sth = 11'h3E8, wth = 11'h000, a1, a2, cf, spv, fbv;
  logic [2:0] ssel = 3'h3, fsel = 3'h4;
  logic [15:0] kp = 16'h0000, ti = 16'h000A, ltime = 16'hFFFF, dly = 16'h0001, fmax = 16'h1388, td = 16'h0000;
  logic [13:0] sper = 14'h0001;
  logic signed [16:0] fbase = 17'h00064, fcmd, rout;
  int error_cnt = 0, tests_run = 0, cyc = 0, ex = 0;
  sensor_model snr (.lvl_one(l1), .lvl_two(l2), .lvl_link(lc), .analog_input_one(a1),
    .analog_input_two(a2), .comm_feedback(cf));
  process_pid_regulator #(.TICK_CYCLES(4)) dut (.mclk(mclk), .nrst(nrst), .analog_input_one(a1),
    .analog_input_two(a2), .comm_feedback(cf), .comm_setpoint(csp), .multi_speed_setpoint(msp),
    .digital_setpoint(dsp), .setpoint_source_select(ssel), .feedback_source_select(fsel),
    .output_polarity(pol), .proportional_gain(kp), .integral_time(ti), .derivative_time(td),
    .sampling_period(sper), .deviation_limit(dlim), .loss_detect_level(llvl), .loss_detect_time(ltime),
    .sleep_threshold(sth), .wakeup_threshold(wth), .sleep_wake_delay(dly), .maximum_frequency(fmax),
    .frequency_base(fbase), .near_lower_limit(nll), .loss_fault_clear(lclr), .frequency_command(fcmd),
    .regulator_output(rout), .setpoint_value(spv), .feedback_value(fbv), .loss_fault(lf), .sleeping(slp),
    .sample_done(sd));
  // ==========================================================
  // Clock, and a cycle ceiling against hangs
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      error_cnt++;
      $display("[FAIL] cycle limit expected %0d seen %0d", 6000, cyc);
      end_sim();
    end
  end
  // ==========================================================
  // Reference model and reporting
  function automatic int fb_m(int s, int a, int b, int c);
    case (s)
      1: return b;
      2: return a + b > 1000 ? 1000 : a + b;
      3: return a > b ? a - b : 0;
      4: return c;
      default: return a;
    endcase
  endfunction : fb_m
  function automatic int sp_m(int s);
    case (s)
      1: return l1;
      2: return l2;
      3: return csp;
      4: return msp;
      default: return dsp;
    endcase
  endfunction : sp_m
  // Truncation toward zero matches the hardware divider
  function automatic int p_m(int sp, int fb);
    longint e, f, p;
    f = fmax;
    e = pol ? fb - sp : sp - fb;
    p = longint'(kp) * e * f / 10000000;
    return int'(p > f ? f : p < -f ? -f : p);
  endfunction : p_m
  // A full-scale change within one derivative time is worth maximum frequency
  function automatic int d_m(int dlt, int ts);
    longint d, f;
    f = fmax;
    d = longint'(td) * dlt * f / (1000 * ts);
    return int'(d > f ? f : d < -f ? -f : d);
  endfunction : d_m
  task automatic chk(input string nm, input int e, input logic signed [31:0] s);
    tests_run++;
    if (s !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %0d seen %0d", nm, e, s);
    end
  endtask : chk
  task automatic strobes(input int n);
    repeat (n) @(posedge sd);
    @(negedge mclk);
  endtask : strobes
  task automatic end_sim;
    if (error_cnt == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : end_sim
  // ==========================================================
  // Main sequence
  initial begin
    void'($urandom(32'h310009FE));
    repeat (10) @(negedge mclk);
    nrst = 1'b1;
    strobes(5);
    chk("integral half", 2500, rout);
    strobes(5);
    chk("integral full", 5000, rout);
    // Second reset clears the integrator before the proportional work
    ti = 16'h0000;
    nrst = 1'b0;
    @(negedge mclk);
    nrst = 1'b1;
    for (int i = 0; i < 40; i++) begin
      {l1, l2, lc} = {11'($urandom % 1001), 11'($urandom % 1001), 11'($urandom % 1001)};
      {msp, dsp, csp} = {11'($urandom % 1001), 11'($urandom % 1001), 11'($urandom % 1001)};
      if (i % 3 == 0) l2 = l1;
      fsel = 3'(i % 8);
      ssel = 3'(i / 5);
      @(negedge mclk);
      chk("feedback", fb_m(fsel, l1, l2, lc), fbv);
      chk("setpoint", sp_m(ssel), spv);
    end
    {fsel, ssel} = {3'h4, 3'h3};
    for (int j = 0; j < 12; j++) begin
      kp = j == 0 ? 16'h2710 : 16'($urandom % 10001);
      pol = j[0];
      csp = j == 0 ? 11'h3E8 : 11'(500 + $urandom % 501);
      lc = j == 0 ? 11'h000 : 11'($urandom % 500);
      strobes(2);
      ex = p_m(csp, lc);
      chk("regulator", ex, rout);
    end
    dlim = 11'h3E8;
    lc = 11'h064;
    // No strobe comes while the deviation sits inside the band, so wait by cycles
    repeat (12) @(negedge mclk);
    chk("dead band", ex, rout);
    // Derivative alone: a steady level gives nothing, a step gives a kick
    {dlim, kp, pol, td, csp, lc} = {11'h000, 16'h0000, 1'b0, 16'h0002, 11'h3E8, 11'h000};
    strobes(2);
    chk("derivative level", 0, rout);
    lc = 11'h064;
    strobes(1);
    chk("derivative step", d_m(-100, 1), rout);
    // Strobe spacing: automatic is ten ticks of four cycles, then three ticks
    for (int k = 0; k < 2; k++) begin
      sper = k == 0 ? 14'h0000 : 14'h0003;
      strobes(1);
      ex = cyc;
      strobes(1);
      chk("sample spacing", k == 0 ? 40 : 12, cyc - ex);
    end
    {dlim, lc, ltime} = {11'h000, 11'h000, 16'h0001};
    chk("loss early", 0, lf);
    repeat (100) @(negedge mclk);
    chk("loss raised", 1, lf);
    lclr = 1'b1;
    @(negedge mclk);
    chk("loss set wins", 1, lf);
    lc = 11'h3E8;
    @(negedge mclk);
    lclr = 1'b0;
    repeat (100) @(negedge mclk);
    chk("loss cleared", 0, lf);
    {pol, nll, sth, wth, lc} = {1'b0, 1'b1, 11'h1F4, 11'h064, 11'h320};
    repeat (100) @(negedge mclk);
    chk("asleep", 1, slp);
    chk("asleep command", 0, fcmd);
    lc = 11'h032;
    repeat (100) @(negedge mclk);
    chk("awake", 0, slp);
    end_sim();
  end
endmodule : tb
`default_nettype wire
